/* inc/lacp_defines.svh */
`ifndef LACP_DEFINES_SVH
`define LACP_DEFINES_SVH

// ****************************************
// isa port offsets from the emulation base
// ****************************************
`define LACP_OFS_RESET      4'h6
`define LACP_OFS_SYNSEL     4'h8
`define LACP_OFS_SYNDAT     4'h9
`define LACP_OFS_REPLY      4'hA
`define LACP_OFS_CMD        4'hC
`define LACP_OFS_AVAIL      4'hE

// ****************************************
// fixed synthesis addresses and defaults
// ****************************************
`define LACP_FIX_SYNSEL     16'h0388
`define LACP_FIX_SYNDAT     16'h0389
`define LACP_BASE_DEF       16'h0220
`define LACP_CTRL_RST       16'h0040
`define LACP_CTRL_ADDR_DEF  16'h0200
`define LACP_CTRL_EMU_BIT   6
`define LACP_FLAG_BIT       7
`define LACP_RESET_CMD      8'h01

// ****************************************
// dsp i/o port numbers
// ****************************************
`define LACP_DSP_SYN        2'h0
`define LACP_DSP_MBOX       2'h3

`endif

/* inc/lacp_pkg.sv */
`default_nettype none
package lacp_pkg;

   // isa host bus request, one cycle per strobe
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        byteHigh;
   } lacp_isa_t;

   // dsp i/o request, one cycle per strobe
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  port;
      logic [15:0] wdata;
   } lacp_dsp_t;

   // whole block state
   typedef struct packed {
      logic [15:0] ctrl;
      logic [7:0]  synSel;
      logic [7:0]  synDat;
      logic [7:0]  synStat;
      logic [7:0]  reply;
      logic [7:0]  cmdBuf;
      logic        cmdFull;
      logic        dataAvail;
      logic        dspReset;
      logic        emuResetReq;
      logic        dspInt2;
      logic [15:0] isaRdata;
      logic [15:0] dspRdata;
   } lacp_state_t;

endpackage
`default_nettype wire

/* src/lacp_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "lacp_defines.svh"
// Contract
// RULE_01 - reset loads control default, emulation mode
// RULE_02 - isa write updates control register
// RULE_03 - dsp system reset restores control bits 7..0
// RULE_04 - 16-bit ports, read high byte undefined
// RULE_05 - decode emulated ports at base offsets
// RULE_06 - reset port write of one starts reset
// RULE_07 - other value releases dsp, echoes inverted
// RULE_08 - synthesis ports also at 388/389
// RULE_09 - 8-bit synthesis data from high lane
// RULE_10 - select low, data high of port 0
// RULE_11 - synthesis data write raises interrupt 2
// RULE_12 - dsp port 0 low byte is status
// RULE_13 - reply register loaded by dsp port 3
// RULE_14 - port 3 write sets avail, read clears
// RULE_15 - command buffer host written, dsp read
// RULE_16 - command write sets full, interrupt 2
// RULE_17 - dsp port 3 read clears full flag
// RULE_18 - command read high byte undefined (zero)
// RULE_19 - host keeps control default in emulation; the code takes host control writes in every mode
// RULE_20 - interrupt 2 is one-cycle ored pulse
module lacp_port
   import lacp_pkg::*;
#(
   parameter logic [15:0] BASE_ADDR = `LACP_BASE_DEF,
   parameter logic [15:0] CTRL_ADDR = `LACP_CTRL_ADDR_DEF
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // isa host side, already in this clock domain
   input  wire lacp_isa_t   isaReq,
   output var  logic [15:0] isaRdata,
   // dsp side
   input  wire lacp_dsp_t   dspReq,
   input  wire logic        dspSysReset,
   output var  logic [15:0] dspRdata,
   output var  logic        dspInt2,
   output var  logic        dspReset,
   output var  logic        emuResetReq,
   output var  logic [15:0] ctrlReg
);

   // ****************************************
   // elaboration checks
   // ****************************************
   // base must leave the low nibble free for the port offsets
   if (BASE_ADDR[3:0] != 4'h0) begin : gBaseChk
      $error("BASE_ADDR must be 16-byte aligned");
   end
   // a control address inside the window would shadow a port
   if (CTRL_ADDR[15:4] == BASE_ADDR[15:4]) begin : gCtrlChk
      $error("CTRL_ADDR must lie outside the port window");
   end
   // nor may it alias one of the fixed synthesis addresses
   if (CTRL_ADDR == `LACP_FIX_SYNSEL
       || CTRL_ADDR == `LACP_FIX_SYNDAT) begin : gFixChk
      $error("CTRL_ADDR must not alias the synthesis pair");
   end
   // low control byte that the dsp system reset restores
   localparam logic [7:0] CTRL_RST_LOW = 8'(`LACP_CTRL_RST);

   // ****************************************
   // assertion clock
   // ****************************************
   // every check below runs on this clock; all but AST_RESET_CTRL rest in reset
   default clocking cbChk @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   // ****************************************
   // state
   // ****************************************
   lacp_state_t st_q;          // registered state
   lacp_state_t st_d;          // next state
   logic        inBase;        // address in the emulation window
   logic [3:0]  ofs;           // offset within the window
   logic        hitSel;        // register-select / status port
   logic        hitDat;        // synthesis data port
   logic [7:0]  wByte;         // low lane of host write
   logic [7:0]  datByte;       // synthesis data byte, lane chosen
   logic        synDatWr;      // host wrote synthesis data
   logic        cmdWr;         // host wrote command buffer
   logic        emuMode;       // emulation mode bit
   logic        hitReset;      // emulation reset port
   logic        hitReply;      // reply data port
   logic        hitCmd;        // command buffer / write status port
   logic        hitAvail;      // data-available status port
   logic        hitCtrl;       // control register address

   assign inBase  = (isaReq.addr[15:4] == BASE_ADDR[15:4]);
   assign ofs     = isaReq.addr[3:0];
   assign wByte   = isaReq.wdata[7:0];
   assign emuMode = st_q.ctrl[`LACP_CTRL_EMU_BIT];

   // one match each for the reset, reply, command and available ports plus the control address, shared with the checks below
   assign hitReset = inBase && ofs == `LACP_OFS_RESET;
   assign hitReply = inBase && ofs == `LACP_OFS_REPLY;
   assign hitCmd   = inBase && ofs == `LACP_OFS_CMD;
   assign hitAvail = inBase && ofs == `LACP_OFS_AVAIL;
   assign hitCtrl  = (isaReq.addr == CTRL_ADDR);

   // decode both the base window and the fixed synthesis pair
   assign hitSel = (inBase && ofs == `LACP_OFS_SYNSEL)          // RULE_05
                || (isaReq.addr == `LACP_FIX_SYNSEL);            // RULE_08
   assign hitDat = (inBase && ofs == `LACP_OFS_SYNDAT)          // RULE_05
                || (isaReq.addr == `LACP_FIX_SYNDAT);            // RULE_08

   // 8-bit cycles route the odd-port byte onto the upper lane
   assign datByte = isaReq.byteHigh ? isaReq.wdata[15:8]        // RULE_09
                                    : wByte;

   assign synDatWr = isaReq.wr && hitDat;
   assign cmdWr    = isaReq.wr && hitCmd;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      st_d          = st_q;
      st_d.dspInt2  = 1'b0;
      st_d.isaRdata = 16'h0000;
      st_d.dspRdata = 16'h0000;

      // host writes; control register first
      if (isaReq.wr && isaReq.addr == CTRL_ADDR) begin
         st_d.ctrl = isaReq.wdata;                               // RULE_02
      end else if (isaReq.wr && inBase && ofs == `LACP_OFS_RESET) begin
         if (wByte == `LACP_RESET_CMD) begin
            st_d.emuResetReq = 1'b1;                             // RULE_06
            st_d.dspReset    = 1'b1;
         end else begin
            st_d.emuResetReq = 1'b0;                             // RULE_07
            st_d.dspReset    = 1'b0;
            st_d.reply       = ~wByte;                           // RULE_07
         end
      end else if (isaReq.wr && hitSel && emuMode) begin
         st_d.synSel = wByte;                                    // RULE_10
      end else if (synDatWr && emuMode) begin
         st_d.synDat = datByte;                                  // RULE_10
      end else if (cmdWr) begin
         st_d.cmdBuf = wByte;                                    // RULE_15
      end

      // dsp system reset restores the low control byte
      if (dspSysReset) begin
         st_d.ctrl[7:0] = CTRL_RST_LOW;                          // RULE_03
      end

      // interrupt 2: one pulse for either host event
      st_d.dspInt2 = synDatWr || cmdWr;  // RULE_11 RULE_16 RULE_20

      // dsp writes
      if (dspReq.wr && dspReq.port == `LACP_DSP_SYN && emuMode) begin
         st_d.synStat = dspReq.wdata[7:0];                       // RULE_12
      end
      if (dspReq.wr && dspReq.port == `LACP_DSP_MBOX) begin
         st_d.reply = dspReq.wdata[7:0];                         // RULE_13
      end

      // dsp reads
      if (dspReq.rd && dspReq.port == `LACP_DSP_SYN) begin
         st_d.dspRdata = {st_q.synDat, st_q.synSel};             // RULE_10
      end else if (dspReq.rd && dspReq.port == `LACP_DSP_MBOX) begin
         // upper byte is don't-care; zero keeps it deterministic
         st_d.dspRdata = {8'h00, st_q.cmdBuf};  // RULE_15 RULE_18
      end

      // full flag: host set wins over a same-cycle dsp clear
      if (dspReq.rd && dspReq.port == `LACP_DSP_MBOX) begin
         st_d.cmdFull = 1'b0;                                    // RULE_17
      end
      if (cmdWr) begin
         st_d.cmdFull = 1'b1;                                    // RULE_16
      end

      // available flag: dsp set wins over a same-cycle host clear
      if (isaReq.rd && inBase && ofs == `LACP_OFS_REPLY) begin
         st_d.dataAvail = 1'b0;                                  // RULE_14
      end
      if (dspReq.wr && dspReq.port == `LACP_DSP_MBOX) begin
         st_d.dataAvail = 1'b1;                                  // RULE_14
      end

      // host reads; port upper byte undefined, driven as zero; control read is full width
      if (isaReq.rd && hitSel) begin
         st_d.isaRdata = {8'h00, st_q.synStat};  // RULE_04 RULE_12
      end else if (isaReq.rd && inBase && ofs == `LACP_OFS_REPLY) begin
         st_d.isaRdata = {8'h00, st_q.reply};                    // RULE_04
      end else if (isaReq.rd && inBase && ofs == `LACP_OFS_CMD) begin
         st_d.isaRdata = {8'h00, st_q.cmdFull, 7'h00};           // RULE_16
      end else if (isaReq.rd && inBase && ofs == `LACP_OFS_AVAIL) begin
         st_d.isaRdata = {8'h00, st_q.dataAvail, 7'h00};         // RULE_14
      end else if (isaReq.rd && isaReq.addr == CTRL_ADDR) begin
         st_d.isaRdata = st_q.ctrl;
      end

      // reset values
      if (srst) begin
         st_d             = '0;
         st_d.ctrl        = `LACP_CTRL_RST;                      // RULE_01
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge ref_clk) begin
      st_q <= st_d;
   end

   assign isaRdata    = st_q.isaRdata;
   assign dspRdata    = st_q.dspRdata;
   assign dspInt2     = st_q.dspInt2;
   assign dspReset    = st_q.dspReset;
   assign emuResetReq = st_q.emuResetReq;
   assign ctrlReg     = st_q.ctrl;

   // ****************************************
   // assertions: host writes
   // ****************************************
   // host command write, taken in one cycle
   sequence cmdWrite;
      cmdWr;
   endsequence

   // one cycle on, the full flag and the irq both show
   sequence fullSeen;
      ##1 (st_q.cmdFull && dspInt2);
   endsequence

   // reset must act even though the other checks rest in it
   AST_RESET_CTRL: assert property ( // RULE_01
      disable iff (1'b0)
      srst |=> ctrlReg == `LACP_CTRL_RST)
      else $error("control not default after reset");

   AST_CTRL_WRITE: assert property ( // RULE_02
      (isaReq.wr && hitCtrl && !dspSysReset)
      |=> ctrlReg == $past(isaReq.wdata))
      else $error("control write lost");

   AST_RESET_START: assert property ( // RULE_06
      (isaReq.wr && hitReset && wByte == `LACP_RESET_CMD)
      |=> dspReset && emuResetReq)
      else $error("reset port write of one ignored");

   AST_RESET_ECHO: assert property ( // RULE_07
      (isaReq.wr && hitReset && wByte != `LACP_RESET_CMD && !hitCtrl
       && !(dspReq.wr && dspReq.port == `LACP_DSP_MBOX))
      |=> !dspReset && !emuResetReq && st_q.reply == ~$past(wByte))
      else $error("reset echo wrong");

   AST_SEL_CAPTURE: assert property ( // RULE_10
      (isaReq.wr && hitSel && emuMode)
      |=> st_q.synSel == $past(wByte))
      else $error("select write not captured");

   AST_DAT_LANE: assert property ( // RULE_09
      (synDatWr && emuMode && isaReq.byteHigh)
      |=> st_q.synDat == $past(isaReq.wdata[15:8]))
      else $error("synthesis data from wrong lane");

   AST_FIXED_DAT: assert property ( // RULE_08
      (isaReq.wr && isaReq.addr == `LACP_FIX_SYNDAT
       && isaReq.byteHigh && emuMode)
      |=> st_q.synDat == $past(isaReq.wdata[15:8]))
      else $error("fixed data address not decoded");

   // outside emulation the synthesis pair stays untouched
   AST_SYN_LOCKED: assert property ( // RULE_10
      (isaReq.wr && (hitSel || hitDat) && !emuMode)
      |=> $stable(st_q.synSel) && $stable(st_q.synDat))
      else $error("synthesis write taken outside emulation");

   AST_CMD_CAPTURE: assert property ( // RULE_15
      cmdWr |=> st_q.cmdBuf == $past(wByte))
      else $error("command byte not captured");

   AST_CMD_FLAG: assert property ( // RULE_16
      cmdWrite |-> fullSeen)
      else $error("command write did not set full and irq");

   AST_SYN_IRQ: assert property ( // RULE_11
      synDatWr |=> dspInt2)
      else $error("synthesis write gave no irq");

   // an irq with no fresh event behind it is a stretched pulse
   AST_INT_PULSE: assert property ( // RULE_20
      !(synDatWr || cmdWr) |=> !dspInt2)
      else $error("irq pulse too long");

   // ****************************************
   // assertions: host reads
   // ****************************************
   // read data stands one cycle and is zero otherwise
   AST_ISA_IDLE: assert property ( // RULE_04
      !isaReq.rd |=> isaRdata == 16'h0000)
      else $error("host read data outside a read");

   AST_ISA_UPPER: assert property ( // RULE_04
      (isaReq.rd && !hitCtrl) |=> isaRdata[15:8] == 8'h00)
      else $error("upper byte of a port read not zero");

   AST_STAT_READ: assert property ( // RULE_12
      (isaReq.rd && hitSel) |=> isaRdata[7:0] == $past(st_q.synStat))
      else $error("synthesis status read wrong");

   AST_AVAIL_READ: assert property ( // RULE_14
      (isaReq.rd && hitAvail)
      |=> isaRdata[`LACP_FLAG_BIT] == $past(st_q.dataAvail))
      else $error("available flag read wrong");

   AST_AVAIL_CLEAR: assert property ( // RULE_14
      (isaReq.rd && hitReply
       && !(dspReq.wr && dspReq.port == `LACP_DSP_MBOX))
      |=> !st_q.dataAvail)
      else $error("reply read did not clear available flag");

   // ****************************************
   // assertions: dsp side
   // ****************************************
   AST_DSP_IDLE: assert property ( // RULE_10
      !dspReq.rd |=> dspRdata == 16'h0000)
      else $error("dsp read data outside a read");

   AST_DSP_PORT0: assert property ( // RULE_10
      (dspReq.rd && dspReq.port == `LACP_DSP_SYN)
      |=> dspRdata == {$past(st_q.synDat), $past(st_q.synSel)})
      else $error("port 0 read wrong");

   AST_DSP_PORT3: assert property ( // RULE_18
      (dspReq.rd && dspReq.port == `LACP_DSP_MBOX)
      |=> dspRdata == {8'h00, $past(st_q.cmdBuf)})
      else $error("port 3 read wrong");

   AST_STAT_CAPTURE: assert property ( // RULE_12
      (dspReq.wr && dspReq.port == `LACP_DSP_SYN && emuMode)
      |=> st_q.synStat == $past(dspReq.wdata[7:0]))
      else $error("status byte not captured");

   AST_CMD_CLEAR: assert property ( // RULE_17
      (dspReq.rd && dspReq.port == `LACP_DSP_MBOX && !cmdWr)
      |=> !st_q.cmdFull)
      else $error("full flag not cleared");

   AST_AVAIL_SET: assert property ( // RULE_14
      (dspReq.wr && dspReq.port == `LACP_DSP_MBOX)
      |=> st_q.dataAvail && st_q.reply == $past(dspReq.wdata[7:0]))
      else $error("reply not latched or avail not set");

   AST_DSP_SYS: assert property ( // RULE_03
      dspSysReset |=> ctrlReg[7:0] == CTRL_RST_LOW)
      else $error("low control byte not restored");

endmodule
`default_nettype wire

/* sim/lacp_dsp_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lacp_dsp_model
   import lacp_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        srst,
   // bench command, taken at a rising edge
   input  wire logic        go,
   input  wire logic        goWr,
   input  wire logic [1:0]  goPort,
   input  wire logic [15:0] goData,
   // dsp i/o request toward the port
   output var  lacp_dsp_t   dspReq
);
   // ****************************************
   // one-cycle strobe per bench command
   // ****************************************
   // idle data toggles so a stale bus never passes for a real write
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         dspReq <= '0;
      end else if (!go) begin
         dspReq.wr    <= 1'b0;
         dspReq.rd    <= 1'b0;
         dspReq.wdata <= ~dspReq.wdata;
      end else begin
         dspReq.wr    <= goWr;
         dspReq.rd    <= ~goWr;
         dspReq.port  <= goPort;
         dspReq.wdata <= goData;
      end
   end
endmodule
`default_nettype wire

/* sim/lacp_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module lacp_port_tb
   import lacp_pkg::*;
;
   // table row: write, then read back
   typedef struct packed {
      logic [15:0] wa;
      logic [15:0] wd;
      logic [15:0] ra;
      logic [15:0] exp;
   } lacp_row_t;
   localparam lacp_row_t ROWS [3] = '{
      '{16'h0226, 16'h005A, 16'h022A, 16'h00A5},
      '{16'h022C, 16'h0055, 16'h022C, 16'h0080},
      '{16'h0226, 16'h0033, 16'h022F, 16'h0000}};
   logic        ref_clk, srst, dspSysReset, go, goWr;
   logic [1:0]  goPort;
   logic [15:0] goData, isaRdata, dspRdata, ctrlReg;
   logic        dspInt2, dspReset, emuResetReq;
   lacp_isa_t   isaReq;
   lacp_dsp_t   dspReq;
   int          n_errors, comparisons;

   lacp_port i_lacp_port (.ref_clk(ref_clk), .srst(srst), .isaReq(isaReq),
      .isaRdata(isaRdata), .dspReq(dspReq), .dspSysReset(dspSysReset),
      .dspRdata(dspRdata), .dspInt2(dspInt2), .dspReset(dspReset),
      .emuResetReq(emuResetReq), .ctrlReg(ctrlReg));
   lacp_dsp_model i_lacp_dsp_model (.ref_clk(ref_clk), .srst(srst),
      .go(go), .goWr(goWr), .goPort(goPort), .goData(goData),
      .dspReq(dspReq));

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // host cycle: strobe for one edge, answer settled at next negedge
   task automatic isaOp(input logic w, input logic [15:0] a,
                        input logic [15:0] d, input logic hi);
      @(posedge ref_clk);
      isaReq <= '{wr: w, rd: ~w, addr: a, wdata: d, byteHigh: hi};
      @(posedge ref_clk);
      isaReq <= '0;
      @(negedge ref_clk);
   endtask
   // dsp cycle through the model, which adds one edge
   task automatic dspOp(input logic w, input logic [1:0] p,
                        input logic [15:0] d);
      @(posedge ref_clk);
      go <= 1'b1;
      goWr <= w;
      goPort <= p;
      goData <= d;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic wrap_up();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************
   // clock and watchdog
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // whole run is under a hundred cycles
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      srst = 1'b1;
      isaReq = '0;
      dspSysReset = 1'b0;
      go = 1'b0;
      goWr = 1'b0;
      goPort = 2'h0;
      goData = 16'h0000;
      n_errors = 0;
      comparisons = 0;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      chk(ctrlReg, 16'h0040);
      $display("reset done");
      foreach (ROWS[i]) begin
         isaOp(1'b1, ROWS[i].wa, ROWS[i].wd, 1'b0);
         isaOp(1'b0, ROWS[i].ra, 16'h0000, 1'b0);
         chk(isaRdata, ROWS[i].exp);
      end
      $display("table done");
      // synthesis pair, base then fixed addresses
      isaOp(1'b1, 16'h0228, 16'h0012, 1'b0);
      isaOp(1'b1, 16'h0229, 16'h34CB, 1'b1);
      chk({15'h0, dspInt2}, 16'h0001);
      @(negedge ref_clk) chk({15'h0, dspInt2}, 16'h0000);
      dspOp(1'b0, 2'h0, 16'h0000);
      chk(dspRdata, 16'h3412);
      isaOp(1'b1, 16'h0388, 16'h0056, 1'b0);
      isaOp(1'b1, 16'h0389, 16'h7878, 1'b1);
      dspOp(1'b0, 2'h0, 16'h0000);
      chk(dspRdata, 16'h7856);
      dspOp(1'b1, 2'h0, 16'hFFC3);
      isaOp(1'b0, 16'h0228, 16'h0000, 1'b0);
      chk(isaRdata, 16'h00C3);
      $display("synthesis done");
      // reply mailbox and its flag
      dspOp(1'b1, 2'h3, 16'hEE99);
      isaOp(1'b0, 16'h022E, 16'h0000, 1'b0);
      chk(isaRdata, 16'h0080);
      isaOp(1'b0, 16'h022A, 16'h0000, 1'b0);
      chk(isaRdata, 16'h0099);
      isaOp(1'b0, 16'h022E, 16'h0000, 1'b0);
      chk(isaRdata, 16'h0000);
      // command overwrite while still full, then consume
      isaOp(1'b1, 16'h022C, 16'h006D, 1'b0);
      chk({15'h0, dspInt2}, 16'h0001);
      dspOp(1'b0, 2'h3, 16'h0000);
      chk(dspRdata, 16'h006D);
      isaOp(1'b0, 16'h022C, 16'h0000, 1'b0);
      chk(isaRdata, 16'h0000);
      $display("mailbox done");
      // reset port values
      isaOp(1'b1, 16'h0226, 16'h0001, 1'b0);
      chk({14'h0, dspReset, emuResetReq}, 16'h0003);
      isaOp(1'b1, 16'h0226, 16'h0002, 1'b0);
      chk({14'h0, dspReset, emuResetReq}, 16'h0000);
      // control write leaves emulation; synthesis writes then ignored
      isaOp(1'b1, 16'h0200, 16'h12BF, 1'b0);
      chk(ctrlReg, 16'h12BF);
      isaOp(1'b1, 16'h0228, 16'h0099, 1'b0);
      dspOp(1'b0, 2'h0, 16'h0000);
      chk(dspRdata, 16'h7856);
      @(posedge ref_clk);
      dspSysReset <= 1'b1;
      @(posedge ref_clk);
      dspSysReset <= 1'b0;
      @(negedge ref_clk);
      chk(ctrlReg, 16'h1240);
      // second reset in mid-run
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      chk(ctrlReg, 16'h0040);
      $display("control done");
      wrap_up();
   end
endmodule
`default_nettype wire
